// >>> rtl/msbm_pkg.sv
// Package: modem shared buffer mailbox constants and types
package msbm_pkg;
  // ==========================================================================
  // Widths
  localparam int unsigned ADDR_W    = 11;
  localparam int unsigned DATA_W    = 8;
  localparam int unsigned BUF_DEPTH = 2048;
  // ==========================================================================
  // AP register map (byte addresses, 32-bit words)
  localparam logic [31:0] M2A_ADDR_OFS   = 32'h4118_0000;
  localparam logic [31:0] A2M_ADDR_OFS   = 32'h4118_0004;
  localparam logic [31:0] IRQ_STAT_OFS   = 32'h4118_0008;
  localparam logic [31:0] IRQ_MASK_OFS   = 32'h4118_000c;
  localparam logic [31:0] BUF_WIN_BASE   = 32'h4118_1000;
  localparam logic [31:0] BUF_WIN_MASK   = 32'hffff_f800;
  localparam logic [10:0] M2A_ADDR_RST   = 11'h7fe;
  localparam logic [10:0] A2M_ADDR_RST   = 11'h7ff;
  // Status and mask bit positions
  localparam int unsigned ST_M2A_BIT     = 0;
  localparam int unsigned ST_A2M_ACK_BIT = 1;
  localparam int unsigned ST_W           = 2;
  // ==========================================================================
  // Host end (modem side) cycle counts
  localparam logic [3:0]  HOST_STROBE_CYC = 4'h4;
  localparam logic [3:0]  HOST_SETUP_CYC  = 4'h1;
  localparam logic [3:0]  HOST_HOLD_CYC   = 4'h1;
  typedef enum logic [2:0] {
    MSBM_H_IDLE,
    MSBM_H_SETUP,
    MSBM_H_STROBE,
    MSBM_H_HOLD,
    MSBM_H_DONE
  } msbm_host_state_t;
endpackage

// >>> rtl/msbm_if.sv
// Interface: modem SRAM-style port between device and modem
`timescale 1ns/10ps
`default_nettype none
interface msbm_if;
  logic [10:0] modem_port_addr;
  logic [7:0]  modem_port_data_m2d;
  logic        modem_port_data_m2d_oe_n;
  logic [7:0]  modem_port_data_d2m;
  logic        modem_port_data_d2m_oe_n;
  logic        modem_port_select_n;
  logic        modem_port_write_n;
  logic        modem_port_read_n;
  logic        irq_to_modem_n;
  logic [7:0]  modem_port_data;
  // Wire resolution: whichever end enables its driver owns the bus
  assign modem_port_data = !modem_port_data_d2m_oe_n ? modem_port_data_d2m :
                           !modem_port_data_m2d_oe_n ? modem_port_data_m2d : 8'hff;
  modport device (
    input  modem_port_addr,
    input  modem_port_data,
    output modem_port_data_d2m,
    output modem_port_data_d2m_oe_n,
    input  modem_port_select_n,
    input  modem_port_write_n,
    input  modem_port_read_n,
    output irq_to_modem_n
  );
  modport modem (
    output modem_port_addr,
    input  modem_port_data,
    output modem_port_data_m2d,
    output modem_port_data_m2d_oe_n,
    output modem_port_select_n,
    output modem_port_write_n,
    output modem_port_read_n,
    input  irq_to_modem_n
  );
endinterface
`default_nettype wire

// >>> rtl/msbm_device.sv
// Device end: shared buffer, port address registers, interrupts
//
// Chosen here: strobed register access.
`timescale 1ns/10ps
`default_nettype none
module msbm_device (
  input  wire logic        i_clk,
  input  wire logic        i_reset,
  input  wire logic [31:0] i_ap_addr,
  input  wire logic [31:0] i_ap_wdata,
  input  wire logic        i_ap_wr,
  input  wire logic        i_ap_rd,
  output logic      [31:0] o_ap_rdata,
  output logic             o_ap_irq,
  msbm_if.device           mdm
);
  // ==========================================================================
  // Storage
  logic [7:0]  buf_mem [msbm_pkg::BUF_DEPTH];
  logic [10:0] m2a_addr_ff;
  logic [10:0] a2m_addr_ff;
  logic [1:0]  stat_ff;
  logic [1:0]  mask_ff;
  logic        irq_mdm_ff;
  logic [31:0] ap_rdata_ff;
  logic [7:0]  mdm_rdata_ff;
  logic        mdm_oe_n_ff;
  // ==========================================================================
  // Strobe synchronisers; address sampled every clock, write data captured while the synced write strobe is low
  logic [2:0]  cs_sync_ff;
  logic [2:0]  we_sync_ff;
  logic [2:0]  oe_sync_ff;
  logic [10:0] adr_q_ff;
  logic [7:0]  dat_q_ff;
  logic [7:0]  dat_d1_ff;
  logic        wr_end;
  logic        rd_start;
  logic        rd_end;
  logic        rd_act;

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      cs_sync_ff <= 3'h7;
      we_sync_ff <= 3'h7;
      oe_sync_ff <= 3'h7;
    end else begin
      cs_sync_ff <= {cs_sync_ff[1:0], mdm.modem_port_select_n};
      we_sync_ff <= {we_sync_ff[1:0], mdm.modem_port_write_n};
      oe_sync_ff <= {oe_sync_ff[1:0], mdm.modem_port_read_n};
    end
  end

  // Write data lags one flop and is framed by the synced strobe
  // The bus is released before the completion edge is seen, so keep the last driven byte
  always_ff @(posedge i_clk) begin
    adr_q_ff  <= mdm.modem_port_addr;
    dat_d1_ff <= mdm.modem_port_data;
    if (!we_sync_ff[1]) begin
      dat_q_ff <= dat_d1_ff;
    end
  end

  // Strobe deasserting marks completion: one event per access
  assign wr_end   = !cs_sync_ff[1] && we_sync_ff[1] && !we_sync_ff[2];
  assign rd_act   = !cs_sync_ff[1] && !oe_sync_ff[1];
  assign rd_start = rd_act && oe_sync_ff[2];
  assign rd_end   = oe_sync_ff[1] && !oe_sync_ff[2] && !cs_sync_ff[2];

  // ==========================================================================
  // AP decode
  function automatic logic is_buf(input logic [31:0] a);
    is_buf = (a & msbm_pkg::BUF_WIN_MASK) == msbm_pkg::BUF_WIN_BASE;
  endfunction

  logic        ap_buf_wr;
  logic [10:0] ap_idx;
  assign ap_idx    = i_ap_addr[10:0];
  assign ap_buf_wr = i_ap_wr && is_buf(i_ap_addr);

  // ==========================================================================
  // Shared buffer: AP port and modem port each write through their own path
  always_ff @(posedge i_clk) begin
    if (ap_buf_wr) begin
      buf_mem[ap_idx] <= i_ap_wdata[7:0];
    end
    if (wr_end) begin
      buf_mem[adr_q_ff] <= dat_q_ff;
    end
  end

  // ==========================================================================
  // Port address registers
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      m2a_addr_ff <= msbm_pkg::M2A_ADDR_RST;
      a2m_addr_ff <= msbm_pkg::A2M_ADDR_RST;
    end else if (i_ap_wr) begin
      if (i_ap_addr == msbm_pkg::M2A_ADDR_OFS) begin
        m2a_addr_ff <= i_ap_wdata[10:0];
      end
      if (i_ap_addr == msbm_pkg::A2M_ADDR_OFS) begin
        a2m_addr_ff <= i_ap_wdata[10:0];
      end
    end
  end

  // ==========================================================================
  // AP interrupt status: set wins over write-one-to-clear
  logic [1:0] nxt_stat;
  always_comb begin
    nxt_stat = stat_ff;
    if (i_ap_wr && i_ap_addr == msbm_pkg::IRQ_STAT_OFS) begin
      nxt_stat = stat_ff & ~i_ap_wdata[1:0];
    end
    if (wr_end && adr_q_ff == m2a_addr_ff) begin
      nxt_stat[msbm_pkg::ST_M2A_BIT] = 1'b1;
    end
    if (rd_end && adr_q_ff == a2m_addr_ff && irq_mdm_ff) begin
      nxt_stat[msbm_pkg::ST_A2M_ACK_BIT] = 1'b1;
    end
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      stat_ff <= 2'h0;
      mask_ff <= 2'h0;
    end else begin
      stat_ff <= nxt_stat;
      if (i_ap_wr && i_ap_addr == msbm_pkg::IRQ_MASK_OFS) begin
        mask_ff <= i_ap_wdata[1:0];
      end
    end
  end

  assign o_ap_irq = |(stat_ff & mask_ff);

  // ==========================================================================
  // Interrupt to modem: AP write sets, modem read clears; set wins
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      irq_mdm_ff <= 1'b0;
    end else if (ap_buf_wr && ap_idx == a2m_addr_ff) begin
      irq_mdm_ff <= 1'b1;
    end else if (rd_end && adr_q_ff == a2m_addr_ff) begin
      irq_mdm_ff <= 1'b0;
    end
  end

  assign mdm.irq_to_modem_n = !irq_mdm_ff;

  // ==========================================================================
  // Modem read path; drive only while read strobe is seen active
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      mdm_oe_n_ff <= 1'b1;
    end else begin
      mdm_oe_n_ff <= !rd_act;
    end
  end

  always_ff @(posedge i_clk) begin
    if (rd_act) begin
      mdm_rdata_ff <= buf_mem[adr_q_ff];
    end
  end

  assign mdm.modem_port_data_d2m      = mdm_rdata_ff;
  assign mdm.modem_port_data_d2m_oe_n = mdm_oe_n_ff;

  // ==========================================================================
  // AP register reads, data in the following cycle
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      ap_rdata_ff <= 32'h0;
    end else if (i_ap_rd) begin
      if (i_ap_addr == msbm_pkg::M2A_ADDR_OFS) begin
        ap_rdata_ff <= {21'h0, m2a_addr_ff};
      end else if (i_ap_addr == msbm_pkg::A2M_ADDR_OFS) begin
        ap_rdata_ff <= {21'h0, a2m_addr_ff};
      end else if (i_ap_addr == msbm_pkg::IRQ_STAT_OFS) begin
        ap_rdata_ff <= {29'h0, irq_mdm_ff, stat_ff};
      end else if (i_ap_addr == msbm_pkg::IRQ_MASK_OFS) begin
        ap_rdata_ff <= {30'h0, mask_ff};
      end else if (is_buf(i_ap_addr)) begin
        ap_rdata_ff <= {24'h0, buf_mem[ap_idx]};
      end else begin
        ap_rdata_ff <= 32'h0;
      end
    end else begin
      ap_rdata_ff <= 32'h0;
    end
  end

  assign o_ap_rdata = ap_rdata_ff;
  wire unused_rd_start = rd_start;
endmodule
`default_nettype wire

// >>> rtl/msbm_modem.sv
// Modem end: SRAM-style master issuing reads and writes to the device
`timescale 1ns/10ps
`default_nettype none
module msbm_modem (
  input  wire logic        i_clk,
  input  wire logic        i_reset,
  input  wire logic        i_req,
  input  wire logic        i_req_write,
  input  wire logic [10:0] i_req_addr,
  input  wire logic [7:0]  i_req_wdata,
  output logic             o_busy,
  output logic             o_done,
  output logic      [7:0]  o_rdata,
  output logic             o_irq,
  msbm_if.modem            dev
);
  // ==========================================================================
  // State
  msbm_pkg::msbm_host_state_t state_ff;
  msbm_pkg::msbm_host_state_t nxt_state;
  logic [3:0]  cnt_ff;
  logic        write_ff;
  logic [10:0] addr_ff;
  logic [7:0]  wdata_ff;
  logic [7:0]  rdata_ff;
  logic        done_ff;

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      msbm_pkg::MSBM_H_IDLE:   if (i_req) nxt_state = msbm_pkg::MSBM_H_SETUP;
      msbm_pkg::MSBM_H_SETUP:  if (cnt_ff == 4'h0) nxt_state = msbm_pkg::MSBM_H_STROBE;
      msbm_pkg::MSBM_H_STROBE: if (cnt_ff == 4'h0) nxt_state = msbm_pkg::MSBM_H_HOLD;
      msbm_pkg::MSBM_H_HOLD:   if (cnt_ff == 4'h0) nxt_state = msbm_pkg::MSBM_H_DONE;
      msbm_pkg::MSBM_H_DONE:   nxt_state = msbm_pkg::MSBM_H_IDLE;
      default:                 nxt_state = msbm_pkg::MSBM_H_IDLE;
    endcase
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      state_ff <= msbm_pkg::MSBM_H_IDLE;
      cnt_ff   <= 4'h0;
    end else begin
      state_ff <= nxt_state;
      if (nxt_state != state_ff) begin
        case (nxt_state)
          msbm_pkg::MSBM_H_SETUP:  cnt_ff <= msbm_pkg::HOST_SETUP_CYC - 4'h1;
          msbm_pkg::MSBM_H_STROBE: cnt_ff <= msbm_pkg::HOST_STROBE_CYC - 4'h1;
          msbm_pkg::MSBM_H_HOLD:   cnt_ff <= msbm_pkg::HOST_HOLD_CYC - 4'h1;
          default:                 cnt_ff <= 4'h0;
        endcase
      end else if (cnt_ff != 4'h0) begin
        cnt_ff <= cnt_ff - 4'h1;
      end
    end
  end

  // Request latched once; later requests ignored while busy
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      write_ff <= 1'b0;
      addr_ff  <= 11'h0;
      wdata_ff <= 8'h0;
    end else if (state_ff == msbm_pkg::MSBM_H_IDLE && i_req) begin
      write_ff <= i_req_write;
      addr_ff  <= i_req_addr;
      wdata_ff <= i_req_wdata;
    end
  end

  // Read data captured on the last strobe cycle
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      rdata_ff <= 8'h0;
      done_ff  <= 1'b0;
    end else begin
      done_ff <= (state_ff == msbm_pkg::MSBM_H_HOLD) && (cnt_ff == 4'h0);
      if (state_ff == msbm_pkg::MSBM_H_STROBE && cnt_ff == 4'h0 && !write_ff) begin
        rdata_ff <= dev.modem_port_data;
      end
    end
  end

  // ==========================================================================
  // Pins: select spans setup to hold, data driven through hold on writes
  logic in_cycle;
  assign in_cycle = state_ff != msbm_pkg::MSBM_H_IDLE && state_ff != msbm_pkg::MSBM_H_DONE;
  assign dev.modem_port_addr          = addr_ff;
  assign dev.modem_port_select_n      = !in_cycle;
  assign dev.modem_port_write_n       = !(state_ff == msbm_pkg::MSBM_H_STROBE && write_ff);
  assign dev.modem_port_read_n        = !(state_ff == msbm_pkg::MSBM_H_STROBE && !write_ff);
  assign dev.modem_port_data_m2d      = wdata_ff;
  assign dev.modem_port_data_m2d_oe_n = !(in_cycle && write_ff);

  assign o_busy  = state_ff != msbm_pkg::MSBM_H_IDLE;
  assign o_done  = done_ff;
  assign o_rdata = rdata_ff;
  assign o_irq   = !dev.irq_to_modem_n;
endmodule
`default_nettype wire

// >>> tb/msbm_sva.sv
// Checker: modem port protocol assertions
`timescale 1ns/10ps
`default_nettype none
module msbm_sva (
  input wire logic        i_clk,
  input wire logic        i_reset,
  input wire logic [10:0] modem_port_addr,
  input wire logic [7:0]  modem_port_data_m2d,
  input wire logic        modem_port_data_m2d_oe_n,
  input wire logic        modem_port_data_d2m_oe_n,
  input wire logic        modem_port_select_n,
  input wire logic        modem_port_write_n,
  input wire logic        modem_port_read_n,
  input wire logic        irq_to_modem_n
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_reset);
  // ==========================================================================
  // Wire ownership and strobes
  a_one_driver: assert property (!modem_port_data_d2m_oe_n |-> modem_port_data_m2d_oe_n)
    else $error("both ends drive the data bus");
  a_drive_released: assert property (modem_port_read_n [*6] |-> modem_port_data_d2m_oe_n)
    else $error("device drives data outside a read");
  a_modem_release: assert property (modem_port_select_n [*2] |-> modem_port_data_m2d_oe_n)
    else $error("modem drives data while deselected");
  a_write_selected: assert property (!modem_port_write_n |-> !modem_port_select_n)
    else $error("write strobe without select");
  a_read_selected: assert property (!modem_port_read_n |-> !modem_port_select_n)
    else $error("read strobe without select");
  a_no_both_strobes: assert property (!(!modem_port_write_n && !modem_port_read_n))
    else $error("read and write strobes together");
  a_write_len: assert property ($fell(modem_port_write_n) |=>
    !modem_port_write_n [*3] ##1 modem_port_write_n) else $error("write strobe length wrong");
  a_wdata_stable: assert property ((!modem_port_write_n && !$past(modem_port_write_n))
    |-> $stable(modem_port_data_m2d) && $stable(modem_port_addr))
    else $error("write data or address moved");
  a_raddr_stable: assert property ((!modem_port_read_n && !$past(modem_port_read_n))
    |-> $stable(modem_port_addr)) else $error("read address moved");
  // Only a read may drop the modem request
  a_irq_holds: assert property ((!irq_to_modem_n && modem_port_read_n
    && $past(modem_port_read_n) && $past(modem_port_read_n, 2) && $past(modem_port_read_n, 3)
    && $past(modem_port_read_n, 4)) |=> !irq_to_modem_n) else $error("modem irq dropped");
endmodule
`default_nettype wire

// >>> tb/msbm_bench.sv
// Bench: device and modem ends joined, driven from the AP side and the modem request port
`timescale 1ns/10ps
`default_nettype none
module msbm_bench;
  // ==========================================================================
  // Signals
  logic        i_clk;
  logic        i_reset;
  logic [31:0] ap_addr, ap_wdata, ap_rdata, r;
  logic        ap_wr, ap_rd, ap_irq, req, req_write, busy, done, m_irq;
  logic [10:0] req_addr, idx;
  logic [7:0]  req_wdata, m_rdata, d;
  logic [31:0] seed = 32'h2e62;
  int          err_count = 0;
  int          checks_done = 0;
  msbm_if mif ();
  msbm_device msbm_device_i (.i_clk(i_clk), .i_reset(i_reset), .i_ap_addr(ap_addr),
    .i_ap_wdata(ap_wdata), .i_ap_wr(ap_wr), .i_ap_rd(ap_rd), .o_ap_rdata(ap_rdata),
    .o_ap_irq(ap_irq), .mdm(mif));
  msbm_modem msbm_modem_i (.i_clk(i_clk), .i_reset(i_reset), .i_req(req),
    .i_req_write(req_write), .i_req_addr(req_addr), .i_req_wdata(req_wdata), .o_busy(busy),
    .o_done(done), .o_rdata(m_rdata), .o_irq(m_irq), .dev(mif));
  msbm_sva msbm_sva_i (.i_clk(i_clk), .i_reset(i_reset),
    .modem_port_addr(mif.modem_port_addr), .modem_port_data_m2d(mif.modem_port_data_m2d),
    .modem_port_data_m2d_oe_n(mif.modem_port_data_m2d_oe_n),
    .modem_port_data_d2m_oe_n(mif.modem_port_data_d2m_oe_n),
    .modem_port_select_n(mif.modem_port_select_n), .modem_port_write_n(mif.modem_port_write_n),
    .modem_port_read_n(mif.modem_port_read_n), .irq_to_modem_n(mif.irq_to_modem_n));
  initial begin
    i_clk = 1'b0;
    forever #10 i_clk = ~i_clk;
  end
  // ==========================================================================
  // Helpers
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [31:0] win(input logic [10:0] a);
    return msbm_pkg::BUF_WIN_BASE | {21'h0, a};
  endfunction
  task automatic results;
    if (err_count == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic ap_write(input logic [31:0] a, input logic [31:0] v);
    @(posedge i_clk);
    ap_addr <= a;
    ap_wdata <= v;
    ap_wr <= 1'b1;
    @(posedge i_clk);
    ap_wr <= 1'b0;
    #1;
  endtask
  task automatic ap_rd_chk(input string nm, input logic [31:0] a, input logic [31:0] exp);
    @(posedge i_clk);
    ap_addr <= a;
    ap_rd <= 1'b1;
    @(posedge i_clk);
    ap_rd <= 1'b0;
    #1;
    check(nm, ap_rdata, exp);
  endtask
  // Bounded wait: a modem cycle that never ends closes the run
  task automatic mdm(input logic w, input logic [10:0] a, input logic [7:0] v);
    int n;
    @(posedge i_clk);
    req <= 1'b1;
    req_write <= w;
    req_addr <= a;
    req_wdata <= v;
    @(posedge i_clk);
    req <= 1'b0;
    for (n = 0; n < 40; n++) begin
      @(posedge i_clk);
      #1;
      if (done === 1'b1) break;
    end
    if (n == 40) begin
      err_count++;
      $display("mismatch modem_done expected 1 seen 0");
      results();
    end
    // Device commits the access on the third edge after the strobe rises
    repeat (2) @(posedge i_clk);
    #1;
  endtask
  // Strobe events land three edges after the strobe rises
  task automatic settle;
    repeat (6) @(posedge i_clk);
    #1;
  endtask
  // ==========================================================================
  // Sequence
  initial begin
    i_reset = 1'b1;
    {ap_addr, ap_wdata, ap_wr, ap_rd} = '0;
    {req, req_write, req_addr, req_wdata} = '0;
    repeat (3) @(posedge i_clk);
    i_reset <= 1'b0;
    repeat (4) @(posedge i_clk);
    ap_rd_chk("m2a_reset", msbm_pkg::M2A_ADDR_OFS, 32'h7fe);
    ap_rd_chk("a2m_reset", msbm_pkg::A2M_ADDR_OFS, 32'h7ff);
    ap_write(msbm_pkg::M2A_ADDR_OFS, 32'hffff_f5a5);
    ap_rd_chk("m2a_reserved", msbm_pkg::M2A_ADDR_OFS, 32'h5a5);
    ap_rd_chk("unmapped", 32'h4118_0010, 32'h0);
    ap_write(msbm_pkg::IRQ_MASK_OFS, 32'h3);
    for (int k = 0; k < 8; k++) begin
      r = rnd();
      idx = r[10:0] & 11'h3ff;
      d = r[18:11];
      mdm(1'b1, idx, d);
      check("modem_idle", 32'(busy), 32'h0);
      ap_rd_chk("modem_to_ap", win(idx), {24'h0, d});
      ap_write(win(idx), {24'h0, ~d});
      mdm(1'b0, idx, 8'h00);
      check("ap_to_modem", {24'h0, m_rdata}, {24'h0, ~d});
    end
    mdm(1'b1, 11'h7fe, 8'h11);
    settle();
    ap_rd_chk("old_port", msbm_pkg::IRQ_STAT_OFS, 32'h0);
    mdm(1'b1, 11'h5a5, 8'h3c);
    settle();
    check("ap_irq", 32'(ap_irq), 32'h1);
    ap_rd_chk("event_byte", win(11'h5a5), 32'h3c);
    mdm(1'b0, 11'h5a5, 8'h00);
    settle();
    check("ap_irq_kept", 32'(ap_irq), 32'h1);
    ap_write(msbm_pkg::IRQ_MASK_OFS, 32'h2);
    check("ap_irq_masked", 32'(ap_irq), 32'h0);
    ap_write(msbm_pkg::IRQ_MASK_OFS, 32'h3);
    ap_write(msbm_pkg::IRQ_STAT_OFS, 32'h1);
    check("ap_irq_cleared", 32'(ap_irq), 32'h0);
    ap_write(msbm_pkg::A2M_ADDR_OFS, 32'h600);
    ap_write(win(11'h600), 32'h96);
    settle();
    check("modem_irq", 32'(m_irq), 32'h1);
    check("irq_pin_low", 32'(mif.irq_to_modem_n), 32'h0);
    mdm(1'b1, 11'h010, 8'h01);
    settle();
    check("modem_irq_kept", 32'(m_irq), 32'h1);
    mdm(1'b0, 11'h600, 8'h00);
    check("port_byte", {24'h0, m_rdata}, 32'h96);
    settle();
    check("modem_irq_clear", 32'(m_irq), 32'h0);
    check("ack_irq", 32'(ap_irq), 32'h1);
    ap_rd_chk("ack_status", msbm_pkg::IRQ_STAT_OFS, 32'h2);
    results();
  end
endmodule
`default_nettype wire
